// ### design/sample_store.v
// Purpose: sixteen-word sample memory with registered read data
// Assumes: one write port and one read port on the same clock
// Notes:   contents are not reset; read data lag the address by one edge
`timescale 1ns/1ps
`include "window_alert_map.vh"

module sample_store (
    input  wire                       i_mclk,
    input  wire                       i_sys_rst,
    input  wire                       i_wr_en,
    input  wire [`WA_BUF_AW-1:0]      i_wr_addr,
    input  wire [`WA_DATA_W-1:0]      i_wr_data,
    input  wire [`WA_BUF_AW-1:0]      i_rd_addr,
    output reg  [`WA_DATA_W-1:0]      o_rd_data
);

    reg [`WA_DATA_W-1:0] mem [0:`WA_BUF_DEPTH-1];

    // write port
    always @(posedge i_mclk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // registered read port
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data <= {`WA_DATA_W{1'b0}};
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule

// ### design/window_alert_capture.v
// Purpose: digital window comparator, event counter, alert and sample capture
// Assumes: conversions arrive on i_mclk as one-cycle strobes with data
// Notes:   once capture is done, buffer read index is the age order: index 0 is the oldest sample
`timescale 1ns/1ps
`include "window_alert_map.vh"

// Notes on behaviour
// [RULE1] low comparator asserts when result is at or below low threshold
// [RULE2] high comparator asserts when result is at or above high threshold
// [RULE3] high threshold at full scale trips only on full-scale result
// [RULE4] low threshold at zero trips only on zero result
// [RULE5] crossing either threshold counts as an alert condition
// [RULE6] alert output tells the host a threshold was crossed
// [RULE7] alert waits until comparator holds for programmed consecutive conversions
// [RULE8] buffer holds sixteen results for later host reads
// [RULE9] pre-trigger mode writes continuously, stops once alert fires
// [RULE10] pre-trigger buffer holds trigger sample plus fifteen before it
// [RULE11] post-trigger mode starts writing at the alert-raising conversion
// [RULE12] post-trigger buffer holds trigger sample plus fifteen after, then stops
// [RULE13] per-channel low and high flags latch; host clears with ones
// [RULE14] four-bit id records which channel first raised the alert
// [RULE15] unsigned compares, each channel with its own threshold pair
// [RULE16] event counter clears when a conversion trips neither comparator
module window_alert_capture (
    input  wire                       i_mclk,
    input  wire                       i_sys_rst,
    input  wire                       i_conv_valid,
    input  wire                       i_conv_chan,
    input  wire [`WA_DATA_W-1:0]      i_conv_data,
    input  wire [`WA_DATA_W-1:0]      i_low_thresh0,
    input  wire [`WA_DATA_W-1:0]      i_high_thresh0,
    input  wire [`WA_DATA_W-1:0]      i_low_thresh1,
    input  wire [`WA_DATA_W-1:0]      i_high_thresh1,
    input  wire [`WA_CNT_W-1:0]       i_event_count,
    input  wire                       i_capture_mode,
    input  wire                       i_arm,
    input  wire [1:0]                 i_low_flag_clr,
    input  wire [1:0]                 i_high_flag_clr,
    input  wire [`WA_BUF_AW-1:0]      i_buf_rd_idx,
    output reg                        o_alert,
    output reg                        o_capture_done,
    output reg                        o_low_flag_channel0,
    output reg                        o_low_flag_channel1,
    output reg                        o_high_flag_channel0,
    output reg                        o_high_flag_channel1,
    output reg  [`WA_CHID_W-1:0]      o_first_trigger_channel_id,
    output wire [`WA_DATA_W-1:0]      o_buf_rd_data
);

    reg  [1:0]               state_r;
    reg  [1:0]               state_nxt;
    reg  [`WA_CNT_W-1:0]     evt_cnt0_r;
    reg  [`WA_CNT_W-1:0]     evt_cnt1_r;
    reg  [`WA_BUF_AW-1:0]    wr_ptr_r;
    reg  [`WA_BUF_AW-1:0]    post_cnt_r;
    reg  [`WA_CNT_W-1:0]     cnt_sel;
    reg  [`WA_CNT_W-1:0]     cnt_next;
    reg  [`WA_DATA_W-1:0]    low_sel;
    reg  [`WA_DATA_W-1:0]    high_sel;
    reg                      buf_wr;
    reg  [`WA_CNT_W-1:0]     need;
    wire                     low_hit;
    wire                     high_hit;
    wire                     any_hit;
    wire                     trigger;
    wire [`WA_BUF_AW-1:0]    rd_addr;
    reg  [`WA_CNT_W-1:0]     evt_cnt0_nxt;
    reg  [`WA_CNT_W-1:0]     evt_cnt1_nxt;
    reg  [`WA_BUF_AW-1:0]    wr_ptr_nxt;
    reg  [`WA_BUF_AW-1:0]    post_cnt_nxt;
    reg                      alert_nxt;
    reg                      done_nxt;
    reg  [`WA_CHID_W-1:0]    chid_nxt;
    reg                      low_flag0_nxt;
    reg                      low_flag1_nxt;
    reg                      high_flag0_nxt;
    reg                      high_flag1_nxt;
    wire                     hit_ch0;
    wire                     hit_ch1;

    // pick the threshold pair of the converted channel
    // [RULE15] per-channel thresholds
    always @* begin
        if (i_conv_chan) begin
            low_sel  = i_low_thresh1;
            high_sel = i_high_thresh1;
            cnt_sel  = evt_cnt1_r;
        end else begin
            low_sel  = i_low_thresh0;
            high_sel = i_high_thresh0;
            cnt_sel  = evt_cnt0_r;
        end
    end

    // window compare, plain unsigned; full scale and zero limits fall out
    // [RULE1] low side compare
    // [RULE4] zero low limit
    assign low_hit  = i_conv_valid && (i_conv_data <= low_sel);
    // [RULE2] high side compare
    // [RULE3] full-scale high limit
    assign high_hit = i_conv_valid && (i_conv_data >= high_sel);
    // [RULE5] either side trips
    assign any_hit  = low_hit || high_hit;

    // a count of zero is treated as one conversion
    always @* begin
        need     = i_event_count;
        cnt_next = cnt_sel + 1'b1;
        if (i_event_count == {`WA_CNT_W{1'b0}}) begin
            need = {{(`WA_CNT_W-1){1'b0}}, 1'b1};
        end
        // saturate so a long excursion never wraps back to zero
        if (cnt_sel == {`WA_CNT_W{1'b1}}) begin
            cnt_next = cnt_sel;
        end
    end

    // [RULE7] consecutive count reached; no trigger while re-arming
    assign trigger = any_hit && (cnt_next >= need) && (state_r != `WA_ST_IDLE) &&
                     !o_alert && !i_arm;

    // per-channel event counter next values
    always @* begin
        evt_cnt0_nxt = evt_cnt0_r;
        evt_cnt1_nxt = evt_cnt1_r;
        if (i_arm) begin
            evt_cnt0_nxt = {`WA_CNT_W{1'b0}};
            evt_cnt1_nxt = {`WA_CNT_W{1'b0}};
        end else if (i_conv_valid) begin
            // [RULE16] clear on quiet conversion
            if (!i_conv_chan) begin
                evt_cnt0_nxt = any_hit ? cnt_next : {`WA_CNT_W{1'b0}};
            end else begin
                evt_cnt1_nxt = any_hit ? cnt_next : {`WA_CNT_W{1'b0}};
            end
        end
    end

    // per-channel event counters
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_cnt0_r <= {`WA_CNT_W{1'b0}};
            evt_cnt1_r <= {`WA_CNT_W{1'b0}};
        end else begin
            evt_cnt0_r <= evt_cnt0_nxt;
            evt_cnt1_r <= evt_cnt1_nxt;
        end
    end

    // capture sequencer
    always @* begin
        state_nxt = state_r;
        buf_wr    = 1'b0;
        case (state_r)
            `WA_ST_IDLE: begin
                state_nxt = `WA_ST_IDLE;
            end
            `WA_ST_ARMED: begin
                // [RULE9] pre mode writes every conversion
                if (i_capture_mode == `WA_MODE_PRE) begin
                    buf_wr = i_conv_valid;
                    if (trigger) begin
                        state_nxt = `WA_ST_DONE;
                    end
                end else if (trigger) begin
                    // [RULE11] post mode starts at trigger
                    buf_wr    = 1'b1;
                    state_nxt = `WA_ST_FILL;
                end
            end
            `WA_ST_FILL: begin
                // [RULE12] fifteen more then stop
                buf_wr = i_conv_valid;
                if (i_conv_valid && post_cnt_r == `WA_POST_AFTER - 4'h1) begin
                    state_nxt = `WA_ST_DONE;
                end
            end
            `WA_ST_DONE: begin
                state_nxt = `WA_ST_DONE;
            end
            default: begin
                state_nxt = `WA_ST_IDLE;
            end
        endcase
        if (i_arm) begin
            state_nxt = `WA_ST_ARMED;
            buf_wr    = 1'b0;
        end
    end

    // write pointer and post-trigger counter next values
    always @* begin
        wr_ptr_nxt   = wr_ptr_r;
        post_cnt_nxt = post_cnt_r;
        if (i_arm) begin
            wr_ptr_nxt   = {`WA_BUF_AW{1'b0}};
            post_cnt_nxt = {`WA_BUF_AW{1'b0}};
        end else begin
            // pointer wraps over sixteen slots, overwriting the oldest
            if (buf_wr) begin
                wr_ptr_nxt = wr_ptr_r + 4'h1;
            end
            if (state_r == `WA_ST_FILL && i_conv_valid) begin
                post_cnt_nxt = post_cnt_r + 4'h1;
            end
        end
    end

    // state, write pointer and post-trigger counter
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r    <= `WA_ST_IDLE;
            wr_ptr_r   <= {`WA_BUF_AW{1'b0}};
            post_cnt_r <= {`WA_BUF_AW{1'b0}};
        end else begin
            state_r    <= state_nxt;
            wr_ptr_r   <= wr_ptr_nxt;
            post_cnt_r <= post_cnt_nxt;
        end
    end

    // [RULE10] age-ordered read
    // after a pre capture the pointer sits just past the trigger, so
    // index 0 is the oldest of the last sixteen and index 15 the trigger
    assign rd_addr = (state_r == `WA_ST_DONE) ? i_buf_rd_idx + wr_ptr_r : i_buf_rd_idx;

    // [RULE8] sixteen-entry store
    sample_store u_store (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (buf_wr),
        .i_wr_addr (wr_ptr_r),
        .i_wr_data (i_conv_data),
        .i_rd_addr (rd_addr),
        .o_rd_data (o_buf_rd_data)
    );

    // alert, done and first channel id next values
    always @* begin
        alert_nxt = o_alert;
        chid_nxt  = o_first_trigger_channel_id;
        done_nxt  = (state_nxt == `WA_ST_DONE);
        if (i_arm) begin
            alert_nxt = 1'b0;
            chid_nxt  = `WA_CHID_CH0;
            done_nxt  = 1'b0;
        end else if (trigger) begin
            // [RULE6] raise alert
            alert_nxt = 1'b1;
            // [RULE14] record channel
            chid_nxt  = i_conv_chan ? `WA_CHID_CH1 : `WA_CHID_CH0;
        end
    end

    // alert, done, first channel id
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_alert                    <= 1'b0;
            o_capture_done             <= 1'b0;
            o_first_trigger_channel_id <= `WA_CHID_CH0;
        end else begin
            o_alert                    <= alert_nxt;
            o_capture_done             <= done_nxt;
            o_first_trigger_channel_id <= chid_nxt;
        end
    end

    // triggering conversion split by channel
    assign hit_ch0 = trigger && !i_conv_chan;
    assign hit_ch1 = trigger && i_conv_chan;

    // flag next values; a new hit wins over a clear
    // [RULE13] sticky flags with clear
    always @* begin
        low_flag0_nxt  = o_low_flag_channel0 & ~i_low_flag_clr[0];
        low_flag1_nxt  = o_low_flag_channel1 & ~i_low_flag_clr[1];
        high_flag0_nxt = o_high_flag_channel0 & ~i_high_flag_clr[0];
        high_flag1_nxt = o_high_flag_channel1 & ~i_high_flag_clr[1];
        if (hit_ch0 && low_hit) begin
            low_flag0_nxt = 1'b1;
        end
        if (hit_ch1 && low_hit) begin
            low_flag1_nxt = 1'b1;
        end
        if (hit_ch0 && high_hit) begin
            high_flag0_nxt = 1'b1;
        end
        if (hit_ch1 && high_hit) begin
            high_flag1_nxt = 1'b1;
        end
    end

    // latched per-channel flags
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_low_flag_channel0  <= 1'b0;
            o_low_flag_channel1  <= 1'b0;
            o_high_flag_channel0 <= 1'b0;
            o_high_flag_channel1 <= 1'b0;
        end else begin
            o_low_flag_channel0  <= low_flag0_nxt;
            o_low_flag_channel1  <= low_flag1_nxt;
            o_high_flag_channel0 <= high_flag0_nxt;
            o_high_flag_channel1 <= high_flag1_nxt;
        end
    end

endmodule

// ### include/window_alert_map.vh
// Purpose: constants for the window alert capture block
// Assumes: twelve-bit unsigned conversion results, two channels
// Notes:   widths and depths are fixed
`ifndef WINDOW_ALERT_MAP_VH
`define WINDOW_ALERT_MAP_VH

`define WA_DATA_W        12
`define WA_CNT_W         8
`define WA_BUF_DEPTH     16
`define WA_BUF_AW        4
`define WA_LAST_IDX      4'hF
`define WA_POST_AFTER    4'hF
`define WA_CHID_W        4
`define WA_CHID_CH0      4'h0
`define WA_CHID_CH1      4'h1
`define WA_MODE_PRE      1'b0
`define WA_MODE_POST     1'b1
`define WA_ST_IDLE       2'h0
`define WA_ST_ARMED      2'h1
`define WA_ST_FILL       2'h2
`define WA_ST_DONE       2'h3

`endif

// ### tb/host_model.sv
// Purpose: host that reads the capture buffer and clears flags
// Assumes: read data lag the index by one cycle
// Notes:   serves each completed capture once
`timescale 1ns/1ps
module host_model (
    input  wire         i_mclk,
    input  wire         i_done,
    input  wire  [3:0]  i_chid,
    input  wire  [11:0] i_rd_data,
    output logic [3:0]  o_rd_idx,
    output logic [1:0]  o_clr,
    output logic        o_served
);
    logic [11:0] cap [0:15];
    // wait for done, read, then clear flags
    initial begin
        o_rd_idx = 4'h0;
        o_clr = 2'h0;
        o_served = 1'b0;
        forever begin
            @(negedge i_mclk);
            if (!i_done) o_served = 1'b0;
            else if (!o_served) begin
                for (int k = 0; k < 16; k++) begin
                    o_rd_idx = k[3:0];
                    @(negedge i_mclk);
                    cap[k] = i_rd_data;
                end
                o_clr = i_chid[0] ? 2'h2 : 2'h3;
                @(negedge i_mclk);
                o_clr = 2'h0;
                o_served = 1'b1;
            end
        end
    end
endmodule

// ### tb/window_alert_capture_properties.sv
// Purpose: port assertions for the window alert capture block
// Assumes: capture mode is held steady through a capture
// Notes:   bound from the test top
`timescale 1ns/1ps
`include "window_alert_map.vh"
module window_alert_capture_properties (
    input wire                  i_mclk,
    input wire                  i_sys_rst,
    input wire                  i_conv_valid,
    input wire                  i_conv_chan,
    input wire [`WA_DATA_W-1:0] i_conv_data,
    input wire [`WA_DATA_W-1:0] i_low_thresh0,
    input wire [`WA_DATA_W-1:0] i_high_thresh0,
    input wire [`WA_DATA_W-1:0] i_high_thresh1,
    input wire                  i_capture_mode,
    input wire                  i_arm,
    input wire [1:0]            i_low_flag_clr,
    input wire                  o_alert,
    input wire                  o_capture_done,
    input wire                  o_low_flag_channel0,
    input wire                  o_high_flag_channel1,
    input wire [`WA_CHID_W-1:0] o_first_trigger_channel_id
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_alert_holds: assert property (o_alert && !i_arm |=> o_alert)
        else $error("alert dropped without arm");
    a_alert_cause: assert property ($rose(o_alert) |-> $past(i_conv_valid))
        else $error("alert without a conversion");
    a_pre_done: assert property ($rose(o_alert) && !i_capture_mode |-> o_capture_done)
        else $error("pre capture not done with alert");
    a_post_wait: assert property ($rose(o_alert) && i_capture_mode |->
        !o_capture_done [*8]) else $error("post capture done too early");
    a_low_cause: assert property ($rose(o_low_flag_channel0) |->
        $past(i_conv_valid && !i_conv_chan && i_conv_data <= i_low_thresh0))
        else $error("low flag without low result");
    a_high_cause: assert property ($rose(o_high_flag_channel1) |->
        $past(i_conv_valid && i_conv_chan && i_conv_data >= i_high_thresh1))
        else $error("high flag without high result");
    a_flag_clear: assert property (o_low_flag_channel0 && i_low_flag_clr[0] &&
        !i_conv_valid |=> !o_low_flag_channel0) else $error("flag not cleared");
    a_chid_kept: assert property (o_alert && !i_arm |=>
        $stable(o_first_trigger_channel_id)) else $error("channel id changed");
    a_quiet_none: assert property (i_conv_valid && !i_conv_chan && !o_alert &&
        i_conv_data > i_low_thresh0 && i_conv_data < i_high_thresh0 |=> !o_alert)
        else $error("alert on a quiet conversion");
endmodule

// ### tb/window_alert_capture_test.sv
// Purpose: self-checking test of the window alert capture block
// Assumes: thresholds and mode held through each capture
// Notes:   bench model predicts trigger, flags and buffer
`timescale 1ns/1ps
`include "window_alert_map.vh"
module window_alert_capture_test;
    logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, chn = 1'b0, mode = 1'b0, arm = 1'b0;
    logic [11:0] dat = 12'h0, rd;
    logic [11:0] lo [0:1] = '{12'h0, 12'h0};
    logic [11:0] hi [0:1] = '{12'hFFF, 12'hFFF};
    logic [7:0]  evc = 8'h0;
    logic [3:0]  idx, chid;
    logic [1:0]  clr;
    logic        alert, done, fl0, fl1, fh0, fh1, served;
    int          mismatches = 0, num_checks = 0, need, trig, side, cnt [0:1];
    logic [11:0] hist [$];
    window_alert_capture i_window_alert_capture (.i_mclk(clk), .i_sys_rst(rst),
        .i_conv_valid(vld), .i_conv_chan(chn), .i_conv_data(dat), .i_low_thresh0(lo[0]),
        .i_high_thresh0(hi[0]), .i_low_thresh1(lo[1]), .i_high_thresh1(hi[1]),
        .i_event_count(evc), .i_capture_mode(mode), .i_arm(arm), .i_low_flag_clr(clr),
        .i_high_flag_clr(clr), .i_buf_rd_idx(idx), .o_alert(alert), .o_capture_done(done),
        .o_low_flag_channel0(fl0), .o_low_flag_channel1(fl1), .o_high_flag_channel0(fh0),
        .o_high_flag_channel1(fh1), .o_first_trigger_channel_id(chid), .o_buf_rd_data(rd));
    host_model i_host_model (.i_mclk(clk), .i_done(done), .i_chid(chid), .i_rd_data(rd),
        .o_rd_idx(idx), .o_clr(clr), .o_served(served));
    // compare tasks
    task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e);
        chk_word({11'h0, g}, {11'h0, e});
    endtask
    // one conversion at a falling edge, bench model updated
    task automatic conv(input logic c, input logic [11:0] d);
        logic hit;
        hit = d <= lo[c] || d >= hi[c];
        chn = c;
        dat = d;
        vld = 1'b1;
        @(negedge clk);
        cnt[c] = hit ? cnt[c] + 1 : 0;
        if (trig < 0) begin
            if (mode == `WA_MODE_PRE) hist.push_back(d);
            if (hit && cnt[c] >= need) begin
                trig = c;
                side = d <= lo[c];
            end
        end
        if (trig >= 0 && mode == `WA_MODE_POST && hist.size() < 16) hist.push_back(d);
    endtask
    // one capture: arm, quiet run, broken excursion, trigger, tail
    task automatic run(input int t);
        logic c, bnd, low;
        logic [11:0] hv, qv;
        int base;
        c = t[1];
        bnd = t > 3;
        low = t[0] ^ t[1];
        mode = t[0];
        for (int i = 0; i < 2; i++) begin
            lo[i] = bnd ? 12'h000 : 12'($urandom_range(1023));
            hi[i] = bnd ? 12'hFFF : 12'($urandom_range(4095, 3072));
        end
        evc = 8'(t % 3 == 0 ? 0 : t);
        need = evc == 0 ? 1 : evc;
        hv = low ? (bnd ? 12'h000 : 12'($urandom_range(lo[c])))
                 : (bnd ? 12'hFFF : 12'($urandom_range(4095, hi[c])));
        qv = bnd ? (low ? 12'h001 : 12'hFFE) : 12'h800;
        trig = -1;
        cnt = '{0, 0};
        hist.delete();
        arm = 1'b1;
        @(negedge clk);
        arm = 1'b0;
        repeat (20) conv(1'($urandom_range(1)), 12'($urandom_range(3071, 1024)));
        repeat (need - 1) conv(c, hv);
        conv(c, qv);
        repeat (need) conv(c, hv);
        repeat (mode ? 18 : 5) conv(!c, 12'($urandom));
        vld = 1'b0;
        repeat (2) @(negedge clk);
        chk_flag(alert, trig >= 0);
        chk_word({8'h0, chid}, {11'h0, c});
        chk_flag(fl0, !c && side);
        chk_flag(fl1, c && side);
        chk_flag(fh0, !c && !side);
        chk_flag(fh1, c && !side);
        for (int i = 0; i < 200 && served !== 1'b1; i++) @(negedge clk);
        chk_flag(served, 1'b1);
        chk_flag(done, 1'b1);
        base = mode ? 0 : hist.size() - 16;
        for (int k = 0; k < 16; k++)
            chk_word(i_host_model.cap[k], hist[base + k]);
        chk_flag(fl0 | fl1 | fh0 | fh1, 1'b0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #12.5 clk = ~clk;
    // reset, then every mode, channel and boundary case
    initial begin
        void'($urandom(32'hE382));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int t = 0; t < 6; t++) run(t);
        results();
    end
    // watchdog
    initial begin
        #500000;
        mismatches++;
        results();
    end
endmodule
bind window_alert_capture window_alert_capture_properties i_properties (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_conv_valid(i_conv_valid),
    .i_conv_chan(i_conv_chan), .i_conv_data(i_conv_data), .i_low_thresh0(i_low_thresh0),
    .i_high_thresh0(i_high_thresh0), .i_high_thresh1(i_high_thresh1),
    .i_capture_mode(i_capture_mode), .i_arm(i_arm), .i_low_flag_clr(i_low_flag_clr),
    .o_alert(o_alert), .o_capture_done(o_capture_done),
    .o_low_flag_channel0(o_low_flag_channel0), .o_high_flag_channel1(o_high_flag_channel1),
    .o_first_trigger_channel_id(o_first_trigger_channel_id));
